// File: cpl_protect.sv
// cell voltage and temperature protection with apb registers
module cpl_protect
  import cpl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scan_valid,
  input  wire logic [11:0] cell_max,
  input  wire logic [11:0] cell_min,
  input  wire logic [11:0] die_temp,
  input  wire logic [11:0] ext_sensor1,
  input  wire logic [11:0] ext_sensor2,
  input  wire logic        chg_current,
  input  wire logic        dchg_current,
  input  wire logic        load_sense_hi,
  output logic             chg_switch,
  output logic             prechg_switch,
  output logic             dchg_switch,
  output logic             full_charge_n,
  output logic             fuse_blow_output,
  output logic             shutdown_pin_n,
  output logic             load_sense_pin,
  output logic             balance_en,
  output logic             sleep_req,
  output logic             powerdown_req,
  output logic             temp_input_gain,
  output logic             ext_sensor2_fet_mode
);
  logic [31:0] ctrl_r, ov_r, uv_r, lock_r, eoc_r, slp_r;
  logic [31:0] dly_r, dly2_r, tchg_r, tdch_r, tbal_r;
  logic [31:0] stat, rd_nxt;
  logic        err_nxt;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        wr;

  assign wr = psel && penable && pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= R_CTRL;
      ov_r   <= R_OV;
      uv_r   <= R_UV;
      lock_r <= R_LOCK;
      eoc_r  <= R_EOC;
      slp_r  <= R_SLP;
      dly_r  <= R_DLY;
      dly2_r <= R_DLY2;
      tchg_r <= R_TCHG;
      tdch_r <= R_TDCH;
      tbal_r <= R_TBAL;
    end else if (wr) begin
      if (paddr == A_CTRL) ctrl_r <= pwdata & M_CTRL;
      else if (paddr == A_OV) ov_r <= pwdata & M_PAIR;
      else if (paddr == A_UV) uv_r <= pwdata & M_PAIR;
      else if (paddr == A_LOCK) lock_r <= pwdata & M_PAIR;
      else if (paddr == A_EOC) eoc_r <= pwdata & M_PAIR;
      else if (paddr == A_SLP) slp_r <= pwdata & M_PAIR;
      else if (paddr == A_DLY) dly_r <= pwdata & M_PAIR;
      else if (paddr == A_DLY2) dly2_r <= pwdata & M_PAIR;
      else if (paddr == A_TCHG) tchg_r <= pwdata & M_PAIR;
      else if (paddr == A_TDCH) tdch_r <= pwdata & M_PAIR;
      else if (paddr == A_TBAL) tbal_r <= pwdata & M_PAIR;
    end
  end

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == A_CTRL) rd_nxt = ctrl_r;
    else if (paddr == A_OV) rd_nxt = ov_r;
    else if (paddr == A_UV) rd_nxt = uv_r;
    else if (paddr == A_LOCK) rd_nxt = lock_r;
    else if (paddr == A_EOC) rd_nxt = eoc_r;
    else if (paddr == A_SLP) rd_nxt = slp_r;
    else if (paddr == A_DLY) rd_nxt = dly_r;
    else if (paddr == A_DLY2) rd_nxt = dly2_r;
    else if (paddr == A_TCHG) rd_nxt = tchg_r;
    else if (paddr == A_TDCH) rd_nxt = tdch_r;
    else if (paddr == A_TBAL) rd_nxt = tbal_r;
    else if (paddr == A_STAT) rd_nxt = stat;
    else err_nxt = 1'b1;
  end

  // answer is sampled in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      prdata_r  <= rd_nxt;
      pslverr_r <= err_nxt;
    end
  end
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;
  assign pready  = 1'b1;

  logic        host, x2m;
  logic [3:0]  lpw;
  logic [11:0] ov_thr, ovr_lvl, uv_thr, uvr_lvl, cell_high_lockout_flag_thr, cell_low_lockout_flag_thr;
  logic [11:0] eoc_lvl, lvchg, slp_thr, die_lim;
  assign host     = ctrl_r[C_HOST];
  assign x2m      = ctrl_r[C_X2M];
  assign lpw      = ctrl_r[C_LPW +: 4];
  assign ov_thr   = ov_r[11:0];
  assign ovr_lvl  = ov_r[27:16];
  assign uv_thr   = uv_r[11:0];
  assign uvr_lvl  = uv_r[27:16];
  assign cell_high_lockout_flag_thr = lock_r[11:0];
  assign cell_low_lockout_flag_thr = lock_r[27:16];
  assign eoc_lvl  = eoc_r[11:0];
  assign lvchg    = eoc_r[27:16];
  assign slp_thr  = slp_r[11:0];
  assign die_lim  = slp_r[27:16];
  assign temp_input_gain      = ctrl_r[C_GAIN];
  assign ext_sensor2_fet_mode = x2m;

  // last scan results; conditions stay quiet until the first scan lands
  logic [11:0] vmax_r, vmin_r, dtemp_r, x1_r, x2_r;
  logic        valid_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vmax_r  <= 12'h000;
      vmin_r  <= 12'h000;
      dtemp_r <= 12'h000;
      x1_r    <= 12'h000;
      x2_r    <= 12'h000;
      valid_r <= 1'b0;
    end else if (scan_valid) begin
      vmax_r  <= cell_max;
      vmin_r  <= cell_min;
      dtemp_r <= die_temp;
      x1_r    <= ext_sensor1;
      x2_r    <= ext_sensor2;
      valid_r <= 1'b1;
    end
  end

  logic ls_m_r, ls_s_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_m_r <= 1'b0;
      ls_s_r <= 1'b0;
    end else begin
      ls_m_r <= load_sense_hi;
      ls_s_r <= ls_m_r;
    end
  end

  // free running time base; timers are not aligned to the crossing
  logic [5:0] us_cnt_r, sd_r;
  logic [9:0] usd_r, msd_r;
  logic [7:0] ldph_r;
  logic       us_tk, ms_tk, s_tk, min_tk;
  assign us_tk  = us_cnt_r == 6'(CYC_PER_US - 1);
  assign ms_tk  = us_tk && usd_r == 10'(US_PER_MS - 1);
  assign s_tk   = ms_tk && msd_r == 10'(MS_PER_S - 1);
  assign min_tk = s_tk && sd_r == 6'(S_PER_MIN - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      us_cnt_r <= 6'h00;
      usd_r    <= 10'h000;
      msd_r    <= 10'h000;
      sd_r     <= 6'h00;
      ldph_r   <= 8'h00;
    end else begin
      us_cnt_r <= us_tk ? 6'h00 : us_cnt_r + 6'h01;
      if (us_tk) usd_r <= ms_tk ? 10'h000 : usd_r + 10'h001;
      if (ms_tk) msd_r <= s_tk ? 10'h000 : msd_r + 10'h001;
      if (ms_tk) ldph_r <= ldph_r + 8'h01;
      if (s_tk) sd_r <= min_tk ? 6'h00 : sd_r + 6'h01;
    end
  end

  // 0 high cells, 1 low cells, 2 sleep; one timer each for all cells
  logic [2:0]  tcond, tdone;
  logic [11:0] tdly [3];
  assign tdly[0] = dly_r[11:0];
  assign tdly[1] = dly_r[27:16];
  assign tdly[2] = dly2_r[11:0];
  genvar g;
  for (g = 0; g < 3; g++) begin : g_tmr
    logic [10:0] cnt_r;
    logic        tk;
    always_comb begin
      case (tdly[g][11:10])
        2'b00:   tk = us_tk;
        2'b01:   tk = ms_tk;
        2'b10:   tk = s_tk;
        default: tk = min_tk;
      endcase
    end
    // count+1 ticks: first tick lands anywhere in one unit
    // gated so a scan that ends the condition cannot still toggle the flag
    assign tdone[g] = tcond[g] && cnt_r > {1'b0, tdly[g][9:0]};
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_r <= 11'h000;
      else if (!tcond[g] || tdone[g]) cnt_r <= 11'h000;
      else if (tk) cnt_r <= cnt_r + 11'h001;
    end
  end

  logic    ov_flag_r, uv_flag_r, sleep_r, full_r;
  logic    cell_high_lockout_flag_r, cell_low_lockout_flag_r, fuse_r, ld_rm;
  cpl_ld_e ld_st_r;
  logic [1:0] ld_s_r;
  logic [2:0] cell_high_lockout_flag_cnt_r, cell_low_lockout_flag_cnt_r;
  logic       uv_ok, ld_on;

  assign tcond[0] = valid_r && (ov_flag_r ? vmax_r < ovr_lvl : vmax_r > ov_thr);
  assign tcond[1] = valid_r && (uv_flag_r ? vmin_r > uvr_lvl : vmin_r < uv_thr);
  assign tcond[2] = valid_r && !host && !sleep_r && vmin_r < slp_thr;
  assign uv_ok    = vmin_r > uvr_lvl;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ov_flag_r <= 1'b0;
    else if (tdone[0]) ov_flag_r <= !ov_flag_r;
  end

  // load pulse only while waiting for the load to go away
  assign ld_on = ld_st_r == LD_PULSE && ldph_r < {4'h0, lpw};
  assign ld_rm = load_sense_pin && ls_s_r && uv_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_st_r <= LD_IDLE;
      ld_s_r  <= 2'h0;
    end else begin
      case (ld_st_r)
        LD_IDLE: begin
          ld_s_r <= 2'h0;
          if (uv_flag_r && tcond[1] && tdone[1]) ld_st_r <= LD_WAIT;
        end
        LD_WAIT: begin
          if (!uv_ok || !uv_flag_r) ld_st_r <= LD_IDLE;
          else if (ld_s_r == 2'(UV_EXTRA_S)) ld_st_r <= LD_PULSE;
          else if (s_tk) ld_s_r <= ld_s_r + 2'h1;
        end
        default: begin
          if (!uv_ok || !uv_flag_r || ld_rm) ld_st_r <= LD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) load_sense_pin <= 1'b0;
    else load_sense_pin <= ld_on;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) uv_flag_r <= 1'b0;
    else if (!uv_flag_r && tdone[1]) uv_flag_r <= 1'b1;
    else if (ld_rm) uv_flag_r <= 1'b0;
  end

  // sleep holds until a charger shows up with cells above the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sleep_r <= 1'b0;
    else if (tdone[2]) sleep_r <= 1'b1;
    else if (chg_current && vmin_r >= slp_thr) sleep_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) full_r <= 1'b0;
    else if (valid_r && chg_current && vmax_r > eoc_lvl) full_r <= 1'b1;
    else if (vmax_r < eoc_lvl - EOC_HYST) full_r <= 1'b0;
  end

  // lockouts need consecutive scans so a noisy sample cannot trip them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_high_lockout_flag_cnt_r <= 3'h0;
      cell_low_lockout_flag_cnt_r <= 3'h0;
    end else if (scan_valid) begin
      if (cell_max < cell_high_lockout_flag_thr) cell_high_lockout_flag_cnt_r <= 3'h0;
      else if (cell_high_lockout_flag_cnt_r != 3'(LOCK_SCANS)) cell_high_lockout_flag_cnt_r <= cell_high_lockout_flag_cnt_r + 3'h1;
      if (cell_min >= cell_low_lockout_flag_thr) cell_low_lockout_flag_cnt_r <= 3'h0;
      else if (cell_low_lockout_flag_cnt_r != 3'(LOCK_SCANS)) cell_low_lockout_flag_cnt_r <= cell_low_lockout_flag_cnt_r + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_high_lockout_flag_r <= 1'b0;
      cell_low_lockout_flag_r <= 1'b0;
      fuse_r <= 1'b0;
    end else begin
      if (cell_high_lockout_flag_cnt_r == 3'(LOCK_SCANS)) cell_high_lockout_flag_r <= 1'b1;
      else if (vmax_r < ovr_lvl) cell_high_lockout_flag_r <= 1'b0;
      if (cell_high_lockout_flag_cnt_r == 3'(LOCK_SCANS)) fuse_r <= 1'b1;
      if (cell_low_lockout_flag_cnt_r == 3'(LOCK_SCANS)) cell_low_lockout_flag_r <= 1'b1;
      else if (uv_ok) cell_low_lockout_flag_r <= 1'b0;
    end
  end

  // temperature: 0 charge, 1 discharge, 2 balance; reading falls when hot
  logic        die_hot_r;
  logic [2:0]  hot_r, cold_r;
  logic [11:0] t_hot [3];
  logic [11:0] t_cold [3];
  assign t_hot[0]  = tchg_r[11:0];
  assign t_hot[1]  = tdch_r[11:0];
  assign t_hot[2]  = tbal_r[11:0];
  assign t_cold[0] = tchg_r[27:16];
  assign t_cold[1] = tdch_r[27:16];
  assign t_cold[2] = tbal_r[27:16];
  genvar k;
  for (k = 0; k < 3; k++) begin : g_tmp
    logic use2;
    assign use2 = !(k == 2 && x2m);
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hot_r[k]  <= 1'b0;
        cold_r[k] <= 1'b0;
      end else begin
        hot_r[k]  <= valid_r && (x1_r < t_hot[k] || (use2 && x2_r < t_hot[k]));
        cold_r[k] <= valid_r && (x1_r > t_cold[k] || (use2 && x2_r > t_cold[k]));
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) die_hot_r <= 1'b0;
    else die_hot_r <= valid_r && dtemp_r > die_lim;
  end

  // switch control; host mode keeps cell high lockout and die heat overrides
  logic chg_auto, dch_auto, chg_want, dch_want, pre_sel;
  assign chg_auto = !(ov_flag_r && !(ctrl_r[C_CFOD] && dchg_current))
                    && !hot_r[0] && !cold_r[0] && !sleep_r;
  assign dch_auto = !(uv_flag_r && !(ctrl_r[C_DFOU] && chg_current))
                    && !(cell_low_lockout_flag_r && !ctrl_r[C_PDSL])
                    && !hot_r[1] && !cold_r[1] && !sleep_r;
  assign chg_want = (host ? ctrl_r[C_HCHG] : chg_auto)
                    && !cell_high_lockout_flag_r && !die_hot_r;
  assign dch_want = (host ? ctrl_r[C_HDCH] : dch_auto) && !die_hot_r;
  assign pre_sel  = ctrl_r[C_PREN] && valid_r && vmin_r < lvchg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_switch       <= 1'b0;
      prechg_switch    <= 1'b0;
      dchg_switch      <= 1'b0;
      balance_en       <= 1'b0;
      full_charge_n    <= 1'b1;
      fuse_blow_output <= 1'b0;
      shutdown_pin_n   <= 1'b1;
      sleep_req        <= 1'b0;
      powerdown_req    <= 1'b0;
    end else begin
      chg_switch       <= chg_want && !pre_sel;
      prechg_switch    <= chg_want && pre_sel;
      dchg_switch      <= dch_want;
      balance_en       <= !die_hot_r && (host || !(hot_r[2] || cold_r[2]));
      full_charge_n    <= !full_r;
      fuse_blow_output <= fuse_r;
      shutdown_pin_n   <= !cell_low_lockout_flag_r;
      sleep_req        <= sleep_r && !host;
      powerdown_req    <= cell_low_lockout_flag_r && ctrl_r[C_PDSL];
    end
  end

  assign stat = {16'h0000, prechg_switch, dchg_switch, chg_switch, cold_r, hot_r,
                 die_hot_r, sleep_r, full_r, cell_low_lockout_flag_r, cell_high_lockout_flag_r, uv_flag_r, ov_flag_r};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ov_chg_off_a: assert property (ov_flag_r && !host && !(ctrl_r[C_CFOD] && dchg_current)
    |=> !chg_switch && !prechg_switch) else $error("charge on during cell high");
  ov_release_a: assert property ($fell(ov_flag_r) |-> $past(vmax_r) < $past(ovr_lvl))
    else $error("cell high cleared above release");
  cell_high_lockout_flag_fuse_a: assert property (cell_high_lockout_flag_r |=> fuse_blow_output && !chg_switch && !prechg_switch)
    else $error("lockout response missing");
  uv_dchg_off_a: assert property (uv_flag_r && !host && !(ctrl_r[C_DFOU] && chg_current)
    |=> !dchg_switch) else $error("discharge on during cell low");
  pre_excl_a: assert property (!(chg_switch && prechg_switch))
    else $error("charge and precharge both on");
  cell_low_lockout_flag_sd_a: assert property (cell_low_lockout_flag_r |=> !shutdown_pin_n)
    else $error("shutdown not asserted");
  die_off_a: assert property (die_hot_r |=> !chg_switch && !dchg_switch && !balance_en)
    else $error("die hot with switches on");
  full_pin_a: assert property (full_r |=> !full_charge_n [*1] ##0 !full_charge_n)
    else $error("full charge pin not low");
  ld_gate_a: assert property (load_sense_pin |-> $past(ld_st_r) == LD_PULSE && $past(uv_flag_r))
    else $error("load pulse outside recovery");
  uv_clear_a: assert property ($fell(uv_flag_r) |-> $past(load_sense_pin) && $past(ls_s_r))
    else $error("cell low cleared without load check");
endmodule

// File: cpl_pkg.sv
// constants, register map and types of the cell protection logic
// Contract
// - cell high too long sets flag, charge off
// - charge back on after release time
// - cell high timers free running, delay varies
// - full charge bit and pin with hysteresis
// - cell high lockout: flag, fuse, charge off
// - host takeover leaves charge switching to host
// - option: charge on while discharge flows
// - cell low too long sets flag, discharge off
// - low cells steer charge to precharge switch
// - recovered cells: load sense pulse every 256ms
// - load removed clears low flag, discharge on
// - cell low timers free running, delay varies
// - sleep threshold held: sleep, switches off
// - five low lockout scans: flag, shutdown
// - option: discharge on while charge flows
// - die and two sensors, sensor2 mode
// - one gain bit for all temperatures
// - die hot: flag, no balancing, switches off
// - sensor hot flags turn switch or balancing off
// - host takeover: sensor temperature flags only
// - sensor cold flags turn switch or balancing off
// - sensor2 mode skips balance thresholds
// - sensor conditions clear back in range
// - one shared timer serves all cells
// - delay is 10-bit count plus 2-bit scale
package cpl_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
  localparam int US_PER_MS     = 1000;
  localparam int MS_PER_S      = 1000;
  localparam int S_PER_MIN     = 60;
  localparam int UV_EXTRA_S    = 3;
  localparam int LOCK_SCANS    = 5;
  localparam int EOC_HYST_MV   = 117;
  localparam logic [11:0] EOC_HYST = 12'((EOC_HYST_MV * 4095 * 3) / (8 * 1800));
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_OV   = 8'h04;
  localparam logic [7:0] A_UV   = 8'h08;
  localparam logic [7:0] A_LOCK = 8'h0C;
  localparam logic [7:0] A_EOC  = 8'h10;
  localparam logic [7:0] A_SLP  = 8'h14;
  localparam logic [7:0] A_DLY  = 8'h18;
  localparam logic [7:0] A_DLY2 = 8'h1C;
  localparam logic [7:0] A_TCHG = 8'h20;
  localparam logic [7:0] A_TDCH = 8'h24;
  localparam logic [7:0] A_TBAL = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2C;
  localparam logic [31:0] M_PAIR = 32'h0FFF_0FFF;
  localparam logic [31:0] M_CTRL = 32'h0000_F3F7;
  localparam int C_HOST = 0;
  localparam int C_HCHG = 1;
  localparam int C_HDCH = 2;
  localparam int C_PREN = 4;
  localparam int C_CFOD = 5;
  localparam int C_DFOU = 6;
  localparam int C_PDSL = 7;
  localparam int C_X2M  = 8;
  localparam int C_GAIN = 9;
  localparam int C_LPW  = 12;
  localparam logic [31:0] R_CTRL = 32'h0000_3000;
  localparam logic [31:0] R_OV   = 32'h0E80_0F00;
  localparam logic [31:0] R_UV   = 32'h0700_0600;
  localparam logic [31:0] R_LOCK = 32'h0500_0FA0;
  localparam logic [31:0] R_EOC  = 32'h0500_0E70;
  localparam logic [31:0] R_SLP  = 32'h0FFF_0500;
  localparam logic [31:0] R_DLY  = 32'h0801_0801;
  localparam logic [31:0] R_DLY2 = 32'h0000_0801;
  localparam logic [31:0] R_TCHG = 32'h0C00_0200;
  localparam logic [31:0] R_TDCH = 32'h0C00_0200;
  localparam logic [31:0] R_TBAL = 32'h0C00_0200;
  typedef enum logic [1:0] {LD_IDLE, LD_WAIT, LD_PULSE} cpl_ld_e;
endpackage

// File: cpl_pack_model.sv
// pack side model: cells, sensors and load, scanned on a fixed period
module cpl_pack_model #(
  parameter int SCAN_CYC = 16
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] v_max,
  input  wire logic [11:0] v_min,
  input  wire logic [11:0] v_die,
  input  wire logic [11:0] v_s1,
  input  wire logic [11:0] v_s2,
  input  wire logic        load_gone,
  input  wire logic        load_sense_pin,
  output logic             scan_valid,
  output logic      [11:0] cell_max,
  output logic      [11:0] cell_min,
  output logic      [11:0] die_temp,
  output logic      [11:0] ext_sensor1,
  output logic      [11:0] ext_sensor2,
  output logic             load_sense_hi
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt        <= 0;
      scan_valid <= 1'b0;
    end else begin
      cnt        <= (cnt == SCAN_CYC - 1) ? 0 : cnt + 1;
      scan_valid <= (cnt == SCAN_CYC - 1);
    end
  end

  // buses inverted between scans so a latch that misses scan_valid shows up
  assign cell_max    = scan_valid ? v_max : ~v_max;
  assign cell_min    = scan_valid ? v_min : ~v_min;
  assign die_temp    = scan_valid ? v_die : ~v_die;
  assign ext_sensor1 = scan_valid ? v_s1 : ~v_s1;
  assign ext_sensor2 = scan_valid ? v_s2 : ~v_s2;
  // line only rises above the comparator level when no load pulls it down
  assign load_sense_hi = load_sense_pin & load_gone;
endmodule

// File: testbench.sv
// self-checking testbench of the cell protection logic
`define CHK(NM, EXP, GOT) begin compares++; if ((GOT) !== (EXP)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", NM, EXP, GOT); end end
module testbench
  import cpl_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SCAN = 16;
  localparam logic [7:0] RA [11] = '{A_CTRL, A_OV, A_UV, A_LOCK, A_EOC, A_SLP, A_DLY,
                                      A_DLY2, A_TCHG, A_TDCH, A_TBAL};
  localparam logic [31:0] RV [11] = '{R_CTRL, R_OV, R_UV, R_LOCK, R_EOC, R_SLP, R_DLY,
                                       R_DLY2, R_TCHG, R_TDCH, R_TBAL};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er, host, x2m;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        scan_valid, chg_current, dchg_current, load_sense_hi, load_gone;
  logic [11:0] cell_max, cell_min, die_temp, ext_sensor1, ext_sensor2;
  logic [11:0] v_max, v_min, v_die, v_s1, v_s2;
  logic        chg_switch, prechg_switch, dchg_switch, full_charge_n, fuse_blow_output;
  logic        shutdown_pin_n, load_sense_pin, balance_en, sleep_req, powerdown_req;
  logic        temp_input_gain, ext_sensor2_fet_mode;
  logic [5:0]  e;
  int          err_count, compares;

  cpl_protect cpl_protect_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scan_valid(scan_valid), .cell_max(cell_max), .cell_min(cell_min), .die_temp(die_temp),
    .ext_sensor1(ext_sensor1), .ext_sensor2(ext_sensor2), .chg_current(chg_current),
    .dchg_current(dchg_current), .load_sense_hi(load_sense_hi), .chg_switch(chg_switch),
    .prechg_switch(prechg_switch), .dchg_switch(dchg_switch), .full_charge_n(full_charge_n),
    .fuse_blow_output(fuse_blow_output), .shutdown_pin_n(shutdown_pin_n),
    .load_sense_pin(load_sense_pin), .balance_en(balance_en), .sleep_req(sleep_req),
    .powerdown_req(powerdown_req), .temp_input_gain(temp_input_gain),
    .ext_sensor2_fet_mode(ext_sensor2_fet_mode));

  cpl_pack_model #(.SCAN_CYC(SCAN)) cpl_pack_model_inst (
    .pclk(pclk), .presetn(presetn), .v_max(v_max), .v_min(v_min), .v_die(v_die),
    .v_s1(v_s1), .v_s2(v_s2), .load_gone(load_gone), .load_sense_pin(load_sense_pin),
    .scan_valid(scan_valid), .cell_max(cell_max), .cell_min(cell_min), .die_temp(die_temp),
    .ext_sensor1(ext_sensor1), .ext_sensor2(ext_sensor2), .load_sense_hi(load_sense_hi));

  always #12.5 pclk = ~pclk;

  function automatic logic [5:0] tflags(input logic [11:0] s1, s2, input logic m);
    tflags[0] = s1 < R_TCHG[11:0] || s2 < R_TCHG[11:0];
    tflags[1] = s1 < R_TDCH[11:0] || s2 < R_TDCH[11:0];
    tflags[2] = s1 < R_TBAL[11:0] || (!m && s2 < R_TBAL[11:0]);
    tflags[3] = s1 > R_TCHG[27:16] || s2 > R_TCHG[27:16];
    tflags[4] = s1 > R_TDCH[27:16] || s2 > R_TDCH[27:16];
    tflags[5] = s1 > R_TBAL[27:16] || (!m && s2 > R_TBAL[27:16]);
  endfunction

  // one edge after release, so a following transfer never re-drives in the same step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic scans(input int n, input int settle);
    repeat (n) begin
      do @(posedge pclk); while (scan_valid !== 1'b1);
    end
    repeat (settle) @(posedge pclk);
  endtask

  task automatic st(input int b, input logic x);
    apb(1'b0, A_STAT, 32'h0);
    `CHK("status bit", x, rd[b])
  endtask

  task automatic nom();
    v_max <= 12'hC00;
    v_min <= 12'hC00;
    v_die <= 12'h080;
    v_s1 <= 12'h800;
    v_s2 <= 12'h800;
    chg_current <= 1'b0;
    dchg_current <= 1'b0;
  endtask

  task automatic rst();
    nom();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  task automatic end_sim();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge pclk);
    err_count++;
    end_sim();
  end

  initial begin
    void'($urandom(51));
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    load_gone = 1'b1;
    nom();
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, RA[i], 32'h0);
      `CHK("reset value", RV[i], rd)
    end
    `CHK("gain default", 1'b0, temp_input_gain)
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, A_CTRL, 32'hFFFF_FFFF);
    apb(1'b0, A_CTRL, 32'h0);
    `CHK("ctrl bits", M_CTRL, rd)
    `CHK("gain", 1'b1, temp_input_gain)
    // random sensor readings spread around both threshold sets
    for (int i = 0; i < 24; i++) begin
      host = 1'($urandom_range(0, 1));
      x2m = 1'($urandom_range(0, 1));
      v_s1 <= (i == 0) ? R_TCHG[11:0] : 12'($urandom_range(12'h180, 12'hC80));
      v_s2 <= (i == 1) ? R_TCHG[27:16] + 12'h1 : 12'($urandom_range(12'h180, 12'hC80));
      apb(1'b1, A_CTRL, R_CTRL | 32'h6 | 32'(host) | (32'(x2m) << C_X2M));
      scans(1, 3);
      e = tflags(v_s1, v_s2, x2m);
      apb(1'b0, A_STAT, 32'h0);
      `CHK("temp flags", e, rd[12:7])
      `CHK("chg sw", host | ~(e[0] | e[3]), chg_switch)
      `CHK("dchg sw", host | ~(e[1] | e[4]), dchg_switch)
      if (!host) `CHK("balance", ~(e[2] | e[5]), balance_en)
      `CHK("s2 mode", x2m, ext_sensor2_fet_mode)
    end
    v_s1 <= 12'h800;
    v_s2 <= 12'h800;
    v_die <= 12'h801;
    // reset die limit is full scale, so lower it to make heat reachable
    apb(1'b1, A_SLP, {4'h0, 12'h800, R_SLP[15:0]});
    apb(1'b1, A_CTRL, R_CTRL);
    scans(1, 3);
    `CHK("die chg", 1'b0, chg_switch)
    `CHK("die dchg", 1'b0, dchg_switch)
    `CHK("die bal", 1'b0, balance_en)
    st(6, 1'b1);
    v_die <= 12'h080;
    chg_current <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      v_max <= (i == 0) ? R_EOC[11:0] + 12'h1 : R_EOC[11:0] - EOC_HYST - 12'(i - 1);
      scans(1, 3);
      `CHK("full pin", logic'(i == 2), full_charge_n)
    end
    chg_current <= 1'b0;
    apb(1'b1, A_DLY, 32'h0002_0002);
    v_max <= 12'hF40;
    scans(1, 60);
    `CHK("high early", 1'b1, chg_switch)
    repeat (65) @(posedge pclk);
    `CHK("high chg", 1'b0, chg_switch)
    `CHK("high dchg", 1'b1, dchg_switch)
    st(0, 1'b1);
    apb(1'b1, A_CTRL, R_CTRL | (32'h1 << C_CFOD));
    dchg_current <= 1'b1;
    scans(1, 3);
    `CHK("chg while dchg", 1'b1, chg_switch)
    dchg_current <= 1'b0;
    scans(1, 3);
    `CHK("chg idle", 1'b0, chg_switch)
    apb(1'b1, A_CTRL, R_CTRL);
    v_max <= 12'hE00;
    scans(1, 60);
    `CHK("release early", 1'b0, chg_switch)
    repeat (65) @(posedge pclk);
    `CHK("release chg", 1'b1, chg_switch)
    v_min <= 12'h550;
    scans(1, 125);
    `CHK("low dchg", 1'b0, dchg_switch)
    `CHK("low chg", 1'b1, chg_switch)
    apb(1'b1, A_CTRL, R_CTRL | (32'h1 << C_DFOU));
    chg_current <= 1'b1;
    scans(1, 3);
    `CHK("dchg while chg", 1'b1, dchg_switch)
    chg_current <= 1'b0;
    scans(1, 3);
    `CHK("dchg idle", 1'b0, dchg_switch)
    apb(1'b1, A_EOC, {4'h0, 12'h600, R_EOC[15:0]});
    apb(1'b1, A_CTRL, R_CTRL | (32'h1 << C_PREN));
    scans(1, 3);
    `CHK("prechg", 1'b1, prechg_switch)
    `CHK("prechg chg", 1'b0, chg_switch)
    rst();
    v_max <= 12'hFB0;
    scans(4, 3);
    `CHK("fuse early", 1'b0, fuse_blow_output)
    scans(1, 3);
    `CHK("fuse", 1'b1, fuse_blow_output)
    `CHK("lock chg", 1'b0, chg_switch)
    st(2, 1'b1);
    rst();
    apb(1'b1, A_DLY2, 32'h0000_0002);
    apb(1'b1, A_CTRL, R_CTRL | (32'h1 << C_PDSL));
    v_min <= 12'h4F0;
    scans(4, 3);
    `CHK("sd early", 1'b1, shutdown_pin_n)
    scans(1, 3);
    `CHK("sd", 1'b0, shutdown_pin_n)
    `CHK("pdown", 1'b1, powerdown_req)
    scans(4, 3);
    `CHK("sleep", 1'b1, sleep_req)
    `CHK("sleep chg", 1'b0, chg_switch)
    `CHK("sleep dchg", 1'b0, dchg_switch)
    st(5, 1'b1);
    end_sim();
  end
endmodule
